// [timer_count_clock_select.sv]
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - channel 3-5 bits 7:6 read zero
// - edge field picks rise, fall, both, off
// - source codes 0-5 pick divide 1 to 32
// - codes 6 and 7 count external pins
// - codes 8, 9 angle clocks; rest prohibited
// - channel 6-7 two fields, codes 0-5 divide
// - channel 6-7 bits 7 and 3 read zero
// - reset and standby clear all registers
// - first stage divides pclk by 1 to 32
// - internal source counts on scaled rising edge
module timer_count_clock_select (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standby,
   input wire logic ext_clock_pin_first,
   input wire logic ext_clock_pin_second,
   input wire logic angle_pin_clock,
   input wire logic angle_multiplied_clock,
   output logic [2:0] ch_count_pulse,
   output logic [7:0] div_count_pulse
);
   // Channel 3..5 controls: index 0 is channel 3
   logic [7:0] clk_ctrl_r [0:2];
   // Divider selects: ch6 first, ch6 second, ch7 first, ch7 second
   logic [7:0] div_sel_r [0:3];
   logic [7:0] psc_r; // First stage prescaler setting
   logic [4:0] psc_cnt_r; // First stage divider count
   logic phi_tick_r; // One pulse per internal clock period
   logic [4:0] div_cnt_r; // Second stage count of internal ticks
   logic [31:0] prdata_r; // Read data holding register
   logic pready_r; // Access phase ends when this is high
   logic pslverr_r; // Unmapped address flag
   logic [2:0] ch_pulse_r; // Channel 3..5 count enables
   logic [7:0] div_pulse_r; // Channel 6/7 count enables
   logic [3:0] acc_idx; // Decoded register of this access
   logic acc_first; // First cycle of an access phase
   logic [7:0] rd_val; // Register value being read
   edge_if ev (); // Synchronised external events

   // Map an address to a register index; 15 means unmapped
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      case (a)
         tcs_pkg::OFF_CH3_CTRL: reg_index = 4'h0;
         tcs_pkg::OFF_CH4_CTRL: reg_index = 4'h1;
         tcs_pkg::OFF_CH5_CTRL: reg_index = 4'h2;
         tcs_pkg::OFF_CH6_DIV_FIRST: reg_index = 4'h3;
         tcs_pkg::OFF_CH6_DIV_SECOND: reg_index = 4'h4;
         tcs_pkg::OFF_CH7_DIV_FIRST: reg_index = 4'h5;
         tcs_pkg::OFF_CH7_DIV_SECOND: reg_index = 4'h6;
         tcs_pkg::OFF_PRESCALER: reg_index = 4'h7;
         default: reg_index = 4'hf;
      endcase
   endfunction

   // Rising edge of the scaled clock: all low count bits at one
   function automatic logic scaled_tick(input logic [2:0] code, input logic [4:0] cnt,
                                        input logic tick);
      case (code)
         3'h0: scaled_tick = tick;
         3'h1: scaled_tick = tick & cnt[0];
         3'h2: scaled_tick = tick & (&cnt[1:0]);
         3'h3: scaled_tick = tick & (&cnt[2:0]);
         3'h4: scaled_tick = tick & (&cnt[3:0]);
         tcs_pkg::DIV_MAX: scaled_tick = tick & (&cnt[4:0]);
         default: scaled_tick = 1'b0; // Prohibited codes never count
      endcase
   endfunction

   // Count on the pin edges the edge field selects
   function automatic logic pin_event(input logic [1:0] edge_sel, input logic r,
                                      input logic f);
      case (edge_sel)
         tcs_pkg::EDGE_RISE: pin_event = r;
         tcs_pkg::EDGE_FALL: pin_event = f;
         tcs_pkg::EDGE_BOTH: pin_event = r | f;
         default: pin_event = 1'b0; // Counting disabled
      endcase
   endfunction

   // Outside inputs go through the synchroniser first
   ext_edge_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins({angle_multiplied_clock, angle_pin_clock, ext_clock_pin_second,
             ext_clock_pin_first}),
      .ev(ev.src)
   );

   // Bus decode; the extra wait cycle keeps pready a flop output
   assign acc_idx = reg_index(paddr);
   assign acc_first = psel & penable & ~pready_r;

   // Read mux; stored values already hold reserved bits at zero
   always_comb
   begin
      case (acc_idx)
         4'h0, 4'h1, 4'h2: rd_val = clk_ctrl_r[acc_idx[1:0]];
         4'h3: rd_val = div_sel_r[0];
         4'h4: rd_val = div_sel_r[1];
         4'h5: rd_val = div_sel_r[2];
         4'h6: rd_val = div_sel_r[3];
         4'h7: rd_val = psc_r;
         default: rd_val = tcs_pkg::REG_RESET; // Unmapped reads zero
      endcase
   end

   // Bus handshake: one wait state, error on unmapped address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end
      else
      begin
         pready_r <= acc_first;
         pslverr_r <= acc_first & (acc_idx == 4'hf);
         if (acc_first && !pwrite)
         begin
            prdata_r <= {24'h0, rd_val};
         end
      end
   end

   // Register writes land as the master sees pready; masks clear reserved bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 3; i++)
         begin
            clk_ctrl_r[i] <= tcs_pkg::REG_RESET;
         end
         for (int i = 0; i < 4; i++)
         begin
            div_sel_r[i] <= tcs_pkg::REG_RESET;
         end
         psc_r <= tcs_pkg::REG_RESET;
      end
      else if (standby)
      begin
         // Standby returns every selector to its reset choice
         for (int i = 0; i < 3; i++)
         begin
            clk_ctrl_r[i] <= tcs_pkg::REG_RESET;
         end
         for (int i = 0; i < 4; i++)
         begin
            div_sel_r[i] <= tcs_pkg::REG_RESET;
         end
         psc_r <= tcs_pkg::REG_RESET;
      end
      else if (psel && penable && pready_r && pwrite && pstrb[0])
      begin
         case (acc_idx)
            4'h0, 4'h1, 4'h2:
               clk_ctrl_r[acc_idx[1:0]] <= pwdata[7:0] & tcs_pkg::MASK_CLK_CTRL;
            4'h3: div_sel_r[0] <= pwdata[7:0] & tcs_pkg::MASK_DIV_SEL;
            4'h4: div_sel_r[1] <= pwdata[7:0] & tcs_pkg::MASK_DIV_SEL;
            4'h5: div_sel_r[2] <= pwdata[7:0] & tcs_pkg::MASK_DIV_SEL;
            4'h6: div_sel_r[3] <= pwdata[7:0] & tcs_pkg::MASK_DIV_SEL;
            4'h7: psc_r <= pwdata[7:0] & tcs_pkg::MASK_PRESCALER;
            default:
            begin
               // Unmapped writes are dropped
            end
         endcase
      end
   end

   // First stage: one internal tick every setting+1 clocks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         psc_cnt_r <= 5'h0;
         phi_tick_r <= 1'b0;
      end
      else if (psc_cnt_r >= psc_r[4:0])
      begin
         psc_cnt_r <= 5'h0;
         phi_tick_r <= 1'b1;
      end
      else
      begin
         psc_cnt_r <= psc_cnt_r + 5'h1;
         phi_tick_r <= 1'b0;
      end
   end

   // Second stage: shared count, one scaled edge per ratio wrap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_cnt_r <= 5'h0;
      end
      else if (phi_tick_r)
      begin
         div_cnt_r <= div_cnt_r + 5'h1;
      end
   end

   // Channel 3..5 count enables from the selected source
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ch_pulse_r <= 3'h0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            case (clk_ctrl_r[i][3:0])
               4'h0, 4'h1, 4'h2, 4'h3, 4'h4, tcs_pkg::SRC_DIV32:
                  ch_pulse_r[i] <= scaled_tick(clk_ctrl_r[i][2:0], div_cnt_r,
                                               phi_tick_r);
               tcs_pkg::SRC_PIN_FIRST:
                  ch_pulse_r[i] <= pin_event(clk_ctrl_r[i][tcs_pkg::EDGE_LSB +: 2],
                                             ev.rise[tcs_pkg::EV_PIN_FIRST],
                                             ev.fall[tcs_pkg::EV_PIN_FIRST]);
               tcs_pkg::SRC_PIN_SECOND:
                  ch_pulse_r[i] <= pin_event(clk_ctrl_r[i][tcs_pkg::EDGE_LSB +: 2],
                                             ev.rise[tcs_pkg::EV_PIN_SECOND],
                                             ev.fall[tcs_pkg::EV_PIN_SECOND]);
               // Angle clocks count rising edges; their own enable is upstream
               tcs_pkg::SRC_ANGLE:
                  ch_pulse_r[i] <= ev.rise[tcs_pkg::EV_ANGLE];
               tcs_pkg::SRC_ANGLE_MULT:
                  ch_pulse_r[i] <= ev.rise[tcs_pkg::EV_ANGLE_MULT];
               default: ch_pulse_r[i] <= 1'b0;
            endcase
         end
      end
   end

   // Channel 6/7 enables; even bits use the low field
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_pulse_r <= 8'h0;
      end
      else
      begin
         for (int j = 0; j < 8; j++)
         begin
            if (j % 2 == 0)
            begin
               div_pulse_r[j] <= scaled_tick(div_sel_r[j / 2][tcs_pkg::DIV_LO_LSB +: 3],
                                             div_cnt_r, phi_tick_r);
            end
            else
            begin
               div_pulse_r[j] <= scaled_tick(div_sel_r[j / 2][tcs_pkg::DIV_HI_LSB +: 3],
                                             div_cnt_r, phi_tick_r);
            end
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ch_count_pulse = ch_pulse_r;
   assign div_count_pulse = div_pulse_r;

   // Checks on channel 3, channel 6 first register, standby clearing and the first-stage prescaler

   property p_ch_rsvd_zero;
      @(posedge pclk) disable iff (!presetn)
      (pready && !pwrite && paddr == tcs_pkg::OFF_CH3_CTRL) |-> prdata[7:6] == 2'h0;
   endproperty
   a_ch_rsvd_zero: assert property (p_ch_rsvd_zero)
      else $error("channel control reserved bits read nonzero");

   property p_edge_off;
      @(posedge pclk) disable iff (!presetn)
      (clk_ctrl_r[0][5:4] == tcs_pkg::EDGE_OFF && clk_ctrl_r[0][3:1] == 3'h3)
         |=> !ch_pulse_r[0];
   endproperty
   a_edge_off: assert property (p_edge_off)
      else $error("pin counted with edge field disabled");

   property p_undivided;
      @(posedge pclk) disable iff (!presetn)
      (clk_ctrl_r[0][3:0] == 4'h0) |=> ch_pulse_r[0] == $past(phi_tick_r);
   endproperty
   a_undivided: assert property (p_undivided)
      else $error("undivided source does not follow internal tick");

   property p_pin_rise;
      @(posedge pclk) disable iff (!presetn)
      (clk_ctrl_r[0][5:0] == {tcs_pkg::EDGE_RISE, tcs_pkg::SRC_PIN_FIRST})
         |=> ch_pulse_r[0] == $past(ev.rise[0]);
   endproperty
   a_pin_rise: assert property (p_pin_rise)
      else $error("first pin rising edge not counted");

   property p_prohibited;
      @(posedge pclk) disable iff (!presetn)
      (clk_ctrl_r[0][3:0] > tcs_pkg::SRC_ANGLE_MULT) |=> !ch_pulse_r[0];
   endproperty
   a_prohibited: assert property (p_prohibited)
      else $error("prohibited source code produced a count");

   property p_div_prohibited;
      @(posedge pclk) disable iff (!presetn)
      (div_sel_r[0][2:0] > tcs_pkg::DIV_MAX) |=> !div_pulse_r[0];
   endproperty
   a_div_prohibited: assert property (p_div_prohibited)
      else $error("prohibited divider code produced a count");

   property p_div_rsvd_zero;
      @(posedge pclk) disable iff (!presetn)
      (pready && !pwrite && paddr == tcs_pkg::OFF_CH6_DIV_FIRST)
         |-> prdata[7] == 1'b0 && prdata[3] == 1'b0;
   endproperty
   a_div_rsvd_zero: assert property (p_div_rsvd_zero)
      else $error("divider select reserved bits read nonzero");

   property p_standby_clear;
      @(posedge pclk) disable iff (!presetn)
      standby |=> clk_ctrl_r[0] == tcs_pkg::REG_RESET && div_sel_r[3] == tcs_pkg::REG_RESET
         && psc_r == tcs_pkg::REG_RESET;
   endproperty
   a_standby_clear: assert property (p_standby_clear)
      else $error("standby did not clear registers");

   property p_psc_spacing;
      @(posedge pclk) disable iff (!presetn)
      (phi_tick_r && psc_r == 8'h01 && $stable(psc_r))
         |=> !phi_tick_r ##1 (phi_tick_r || $past(psc_r) != 8'h01);
   endproperty
   a_psc_spacing: assert property (p_psc_spacing)
      else $error("prescaler setting one does not divide by two");

   property p_div2_rate;
      @(posedge pclk) disable iff (!presetn)
      (clk_ctrl_r[0][3:0] == 4'h1) |=> ch_pulse_r[0] == ($past(phi_tick_r)
         && $past(div_cnt_r[0]));
   endproperty
   a_div2_rate: assert property (p_div2_rate)
      else $error("divide by two source counted on wrong tick");
endmodule

// [tcs_pkg.sv]
package tcs_pkg;
   // Register map, byte addresses on the APB word grid
   localparam logic [7:0] OFF_CH3_CTRL = 8'h00;
   localparam logic [7:0] OFF_CH4_CTRL = 8'h04;
   localparam logic [7:0] OFF_CH5_CTRL = 8'h08;
   localparam logic [7:0] OFF_CH6_DIV_FIRST = 8'h0c;
   localparam logic [7:0] OFF_CH6_DIV_SECOND = 8'h10;
   localparam logic [7:0] OFF_CH7_DIV_FIRST = 8'h14;
   localparam logic [7:0] OFF_CH7_DIV_SECOND = 8'h18;
   localparam logic [7:0] OFF_PRESCALER = 8'h1c;
   // Writable bits; everything else reads zero
   localparam logic [7:0] MASK_CLK_CTRL = 8'h3f;
   localparam logic [7:0] MASK_DIV_SEL = 8'h77;
   localparam logic [7:0] MASK_PRESCALER = 8'h1f;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Field positions
   localparam int EDGE_LSB = 4;
   localparam int DIV_HI_LSB = 4;
   localparam int DIV_LO_LSB = 0;
   // Edge field codes
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [1:0] EDGE_OFF = 2'h3;
   // Source field codes
   localparam logic [3:0] SRC_DIV32 = 4'h5;
   localparam logic [3:0] SRC_PIN_FIRST = 4'h6;
   localparam logic [3:0] SRC_PIN_SECOND = 4'h7;
   localparam logic [3:0] SRC_ANGLE = 4'h8;
   localparam logic [3:0] SRC_ANGLE_MULT = 4'h9;
   // Highest legal divider code
   localparam logic [2:0] DIV_MAX = 3'h5;
   // Index of each synchronised input in the edge bundle
   localparam int EV_PIN_FIRST = 0;
   localparam int EV_PIN_SECOND = 1;
   localparam int EV_ANGLE = 2;
   localparam int EV_ANGLE_MULT = 3;
   localparam int EV_N = 4;
endpackage

// [edge_if.sv]
`timescale 1ns/1ps
// Synchronised edge events from the outside count inputs
interface edge_if;
   logic [3:0] rise; // One-cycle pulse per rising edge
   logic [3:0] fall; // One-cycle pulse per falling edge
   modport src (output rise, output fall);
   modport dst (input rise, input fall);
endinterface

// [ext_edge_sync.sv]
`timescale 1ns/1ps
module ext_edge_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] pins,
   edge_if.src ev
);
   logic [3:0] meta_r; // First synchroniser stage, read only by sync_r
   logic [3:0] sync_r; // Second stage, safe to use
   logic [3:0] last_r; // Previous synchronised level for edge detection

   // Two flops against metastability, a third to find edges
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= 4'h0;
         sync_r <= 4'h0;
         last_r <= 4'h0;
      end
      else
      begin
         meta_r <= pins;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   // One pulse per edge, since last_r follows sync_r at once
   assign ev.rise = sync_r & ~last_r;
   assign ev.fall = ~sync_r & last_r;

   property p_rise_single;
      @(posedge pclk) disable iff (!presetn)
      ev.rise[0] |=> !ev.rise[0] && !ev.fall[0];
   endproperty
   a_rise_single: assert property (p_rise_single)
      else $error("rising edge gave more than one pulse");
endmodule

// [ext_clock_source.sv]
`timescale 1ns/1ps
// Outside count sources: two clock pins, the angle pin clock and its multiplied clock
module ext_clock_source (
   input wire logic pclk,
   output logic [3:0] pins
);
   // All sources idle low; nothing runs between bursts
   initial pins = 4'h0;

   // Toggle the sources set in mask together, edges spaced by half pclk periods
   // Spacing of two or more pclk periods keeps every edge visible to a two-flop sampler
   task automatic run(input int edges, input int half, input logic [3:0] mask);
      for (int n = 0; n < edges; n++)
      begin
         repeat (half) @(posedge pclk);
         pins <= pins ^ mask;
      end
   endtask
endmodule

// [timer_count_clock_select_test.sv]
`timescale 1ns/1ps
module timer_count_clock_select_test;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, standby, pready, pslverr, err;
   logic [7:0] paddr, a;
   logic [31:0] pwdata, prdata, seed, r;
   logic [3:0] pstrb, pins;
   logic [2:0] ch_count_pulse;
   logic [7:0] div_count_pulse;
   logic cnt_en; // Pulse counting window
   int cnt[11]; // Running pulse totals, channels 3-5 then the eight divider fields
   int base[11]; // Totals at window start
   int n_errors, checks, p;
   logic [7:0] addrs[8] = '{tcs_pkg::OFF_CH3_CTRL, tcs_pkg::OFF_CH4_CTRL, tcs_pkg::OFF_CH5_CTRL,
      tcs_pkg::OFF_CH6_DIV_FIRST, tcs_pkg::OFF_CH6_DIV_SECOND, tcs_pkg::OFF_CH7_DIV_FIRST,
      tcs_pkg::OFF_CH7_DIV_SECOND, tcs_pkg::OFF_PRESCALER};

   always #5 pclk = ~pclk;

   // Count pulses; outputs are seen here before this edge's updates land
   always @(posedge pclk)
      if (cnt_en)
         for (int i = 0; i < 11; i++)
            cnt[i] += (i < 3) ? ch_count_pulse[i] : div_count_pulse[i - 3];

   ext_clock_source src_u (.pclk(pclk), .pins(pins));

   timer_count_clock_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
      .ext_clock_pin_first(pins[0]), .ext_clock_pin_second(pins[1]),
      .angle_pin_clock(pins[2]), .angle_multiplied_clock(pins[3]),
      .ch_count_pulse(ch_count_pulse), .div_count_pulse(div_count_pulse));

   // Pseudo-random step, fixed seed keeps runs repeatable
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Writable bits of each register
   function automatic logic [7:0] mask_of(input logic [7:0] ad);
      if (ad <= tcs_pkg::OFF_CH5_CTRL)
         return tcs_pkg::MASK_CLK_CTRL;
      if (ad == tcs_pkg::OFF_PRESCALER)
         return tcs_pkg::MASK_PRESCALER;
      return tcs_pkg::MASK_DIV_SEL;
   endfunction

   // Pulses from n pin toggles for an edge field code
   function automatic int ext_exp(input int e, input int n);
      return (e == 3) ? 0 : ((e == 2) ? n : n / 2);
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer, entered just after a rising edge; waits for pready
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
      output logic [31:0] rd, output logic e);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         n_errors++;
         $display("MISMATCH pready expected 1 seen %b", pready);
         print_verdict();
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, ad, d, rd, e);
   endtask

   task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
      logic [31:0] rd;
      logic e;
      apb(1'b0, ad, 32'h0, rd, e);
      chk($sformatf("reg %h", ad), exp, rd);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask

   // Snapshot totals, then count for w edges
   task automatic window(input int w);
      base = cnt;
      cnt_en <= 1'b1;
      repeat (w) @(posedge pclk);
      cnt_en <= 1'b0;
      @(posedge pclk);
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      standby = 1'b0;
      cnt_en = 1'b0;
      seed = 32'h9a2332d5;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Every register clear after reset, hole answers with an error
      for (int i = 0; i < 8; i++)
         rd_chk(addrs[i], 32'h0);
      apb(1'b0, 8'h20, 32'h0, r, err);
      chk("hole pslverr", 32'h1, {31'h0, err});
      chk("hole data", 32'h0, r);
      $display("test reset_values done");
      // All ones first, then random words; reserved bits must read zero
      for (int n = 0; n < 32; n++)
      begin
         seed = lfsr(seed);
         a = addrs[n % 8];
         r = (n < 8) ? 32'hffffffff : seed;
         wr(a, r);
         rd_chk(a, {24'h0, r[7:0] & mask_of(a)});
      end
      // A write without its byte strobe leaves the register alone
      wr(tcs_pkg::OFF_CH3_CTRL, 32'h2a);
      pstrb <= 4'h0;
      wr(tcs_pkg::OFF_CH3_CTRL, 32'h15);
      pstrb <= 4'hf;
      rd_chk(tcs_pkg::OFF_CH3_CTRL, 32'h2a);
      // Standby wipes every register
      standby <= 1'b1;
      repeat (2) @(posedge pclk);
      standby <= 1'b0;
      @(posedge pclk);
      for (int i = 0; i < 8; i++)
         rd_chk(addrs[i], 32'h0);
      $display("test register_access done");
      // Every internal ratio on every channel, random first-stage setting
      for (int k = 0; k < 6; k++)
      begin
         seed = lfsr(seed);
         p = seed[1:0];
         wr(tcs_pkg::OFF_PRESCALER, p);
         for (int i = 0; i < 7; i++)
            wr(addrs[i], (i < 3) ? k : ((k << 4) | k));
         repeat (70) @(posedge pclk);
         window((64 * (p + 1)) << k);
         for (int i = 0; i < 11; i++)
            chk($sformatf("pulses %0d code %0d", i, k), 64, cnt[i] - base[i]);
      end
      $display("test internal_rates done");
      // Prohibited codes give no pulses at all
      wr(tcs_pkg::OFF_PRESCALER, 32'h0);
      wr(tcs_pkg::OFF_CH3_CTRL, 32'h0a);
      wr(tcs_pkg::OFF_CH4_CTRL, 32'h0f);
      wr(tcs_pkg::OFF_CH5_CTRL, 32'h0c);
      for (int i = 3; i < 7; i++)
         wr(addrs[i], (i % 2) ? 32'h76 : 32'h67);
      window(256);
      for (int i = 0; i < 11; i++)
         chk($sformatf("prohibited %0d", i), 0, cnt[i] - base[i]);
      $display("test prohibited_codes done");
      // Pin sources with each edge code; angle input assumed enabled beforehand
      for (int e = 0; e < 4; e++)
      begin
         wr(tcs_pkg::OFF_CH3_CTRL, (e << 4) | 6);
         wr(tcs_pkg::OFF_CH4_CTRL, (e << 4) | 7);
         wr(tcs_pkg::OFF_CH5_CTRL, (e << 4) | (8 + e % 2));
         base = cnt;
         cnt_en <= 1'b1;
         // First pin and angle pin toggle 8 times, second pin and multiplied clock 4
         src_u.run(8, (e % 2) ? 7 : 2, 4'h5);
         src_u.run(4, (e % 2) ? 7 : 2, 4'ha);
         repeat (8) @(posedge pclk);
         cnt_en <= 1'b0;
         @(posedge pclk);
         chk("pin first", ext_exp(e, 8), cnt[0] - base[0]);
         chk("pin second", ext_exp(e, 4), cnt[1] - base[1]);
         chk("angle", (e % 2) ? 2 : 4, cnt[2] - base[2]);
      end
      $display("test external_sources done");
      // A reset in mid-run clears every register again
      wr(tcs_pkg::OFF_PRESCALER, 32'h1f);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 8; i++)
         rd_chk(addrs[i], 32'h0);
      $display("test mid_reset done");
      print_verdict();
   end
endmodule
